//--- inc/exc_seq_pkg.sv
// Constants and types shared by the exception sequencer.
// Assumes a 32-bit core with a single core clock and an active-low asynchronous reset.
// Summary of operation
// - Entry saves state, supervisor mode, vector fetch.
// - Exceptions taken strictly in program order.
// - Older instructions and their faults first.
// - Async precise waits completion and store drain.
// - One at a time; reset/check may preempt.
// - Multiple conditions of one instruction taken sequentially.
// - Faulting address saved; nothing younger completes.
// - Trap and syscall resume at handler's choice.
// - Imprecise FP modes still handled precisely.
// - Maskable interrupts wait next instruction completion; the code takes them when it reaches completion, without cmp_allow_o for it.
// - Idle pipeline takes interrupt once restart known.
// - Reset and check nonmaskable, imprecise, partly recoverable.
// - Every exception reports recoverability in state.
// - Soft or hard reset vectors to 00100.
// - Bus error, check input, parity vector 00200.
package exc_seq_pkg;
  localparam int ADDR_W = 32;
  localparam int MSTATE_W = 32;
  localparam int CAUSE_W = 8;
  // Machine state bit positions.
  localparam int MSTATE_EE_BIT = 15;
  localparam int MSTATE_PR_BIT = 14;
  localparam int MSTATE_CE_BIT = 17;
  localparam int MSTATE_SM_BIT = 16;
  localparam int MSTATE_IR_BIT = 5;
  localparam int MSTATE_DR_BIT = 4;
  localparam int MSTATE_RECOV_BIT = 1;
  localparam logic [MSTATE_W-1:0] MSTATE_RESET = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] PC_RESET = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] VEC_BASE = 32'hfff0_0000;
  localparam logic [ADDR_W-1:0] OFF_RESET = 32'h0000_0100;
  localparam logic [ADDR_W-1:0] OFF_MCHECK = 32'h0000_0200;
  localparam logic [ADDR_W-1:0] OFF_EXT = 32'h0000_0500;
  localparam logic [ADDR_W-1:0] OFF_DEC = 32'h0000_0900;
  localparam logic [ADDR_W-1:0] OFF_CRIT = 32'h0000_0a00;
  localparam logic [ADDR_W-1:0] OFF_MGMT = 32'h0000_1400;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0004;
  // Kinds of exception, in priority order from highest.
  typedef enum logic [2:0] {
    EXC_NONE, EXC_RESET, EXC_MCHECK, EXC_SYNC, EXC_CRIT, EXC_MGMT, EXC_EXT, EXC_DEC
  } exc_kind_t;
  typedef enum {ST_RUN, ST_DRAIN, ST_HANDLER} seq_state_t;
endpackage

//--- core/core_exception_sequencer.sv
// Exception recognition and sequencing for the core's completion stage.
// Assumes the completion pipeline reports the oldest instruction in order and
// holds each fault at completion until this block answers with take or complete.
module core_exception_sequencer (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Completion stage.
  input wire logic cmp_valid_i,
  input wire logic [exc_seq_pkg::ADDR_W-1:0] cmp_pc_i,
  input wire logic cmp_fault_i,
  input wire logic [exc_seq_pkg::ADDR_W-1:0] cmp_fault_off_i,
  input wire logic cmp_fault_next_i,
  input wire logic [exc_seq_pkg::CAUSE_W-1:0] cmp_cause_i,
  input wire logic older_pending_i,
  input wire logic pipe_empty_i,
  input wire logic store_q_empty_i,
  input wire logic fp_imprecise_mode_i,
  // Asynchronous sources.
  input wire logic soft_reset_i,
  input wire logic hard_reset_i,
  input wire logic bus_tea_i,
  input wire logic mcheck_i,
  input wire logic parity_err_i,
  input wire logic ext_int_i,
  input wire logic system_mgmt_interrupt_i,
  input wire logic dec_int_i,
  input wire logic crit_int_i,
  // Handler return.
  input wire logic handler_return_i,
  input wire logic [exc_seq_pkg::ADDR_W-1:0] return_pc_i,
  // Outputs.
  output logic cmp_allow_o,
  output logic flush_o,
  output logic redirect_o,
  output logic [exc_seq_pkg::ADDR_W-1:0] fetch_pc_o,
  output logic [exc_seq_pkg::ADDR_W-1:0] save_restore_pc_o,
  output logic [exc_seq_pkg::MSTATE_W-1:0] save_restore_status_o,
  output logic [exc_seq_pkg::MSTATE_W-1:0] machine_state_reg_o,
  output logic [exc_seq_pkg::CAUSE_W-1:0] data_fault_cause_reg_o,
  output logic busy_o
);
  import exc_seq_pkg::*;

  seq_state_t state_r, state_nxt;
  logic [ADDR_W-1:0] spc_r, spc_nxt, fetch_r, fetch_nxt;
  logic [MSTATE_W-1:0] sstat_r, sstat_nxt, mstate_r, mstate_nxt;
  logic [CAUSE_W-1:0] cause_r, cause_nxt;
  logic redir_r, redir_nxt, flush_r, flush_nxt, allow_r, allow_nxt;
  logic ext_seen_r, ext_seen_nxt;
  // Busy has its own flop so that the output is not decoded from the state.
  logic busy_r, busy_nxt;

  logic reset_req, mcheck_req, async_req;
  exc_kind_t async_kind, take_kind;
  logic take;

  // Offset from the kind; used for async entry and by the checks below.
  function automatic logic [ADDR_W-1:0] kind_off(input exc_kind_t k);
    unique case (k)
      EXC_RESET: kind_off = OFF_RESET;
      EXC_MCHECK: kind_off = OFF_MCHECK;
      EXC_CRIT: kind_off = OFF_CRIT;
      EXC_MGMT: kind_off = OFF_MGMT;
      EXC_EXT: kind_off = OFF_EXT;
      EXC_DEC: kind_off = OFF_DEC;
      default: kind_off = '0;
    endcase
  endfunction

  // Nonmaskable sources ignore every enable bit.
  assign reset_req = soft_reset_i | hard_reset_i;
  assign mcheck_req = bus_tea_i | mcheck_i | parity_err_i;

  // Maskable sources, fixed priority, highest first.
  always_comb begin
    async_kind = EXC_NONE;
    if (crit_int_i && mstate_r[MSTATE_CE_BIT]) begin
      async_kind = EXC_CRIT;
    end else if (system_mgmt_interrupt_i && mstate_r[MSTATE_EE_BIT]) begin
      async_kind = EXC_MGMT;
    end else if (ext_int_i && mstate_r[MSTATE_EE_BIT]) begin
      async_kind = EXC_EXT;
    end else if (dec_int_i && mstate_r[MSTATE_EE_BIT]) begin
      async_kind = EXC_DEC;
    end
    async_req = (async_kind != EXC_NONE);
  end

  always_comb begin
    state_nxt = state_r;
    spc_nxt = spc_r;
    sstat_nxt = sstat_r;
    mstate_nxt = mstate_r;
    fetch_nxt = fetch_r;
    cause_nxt = cause_r;
    redir_nxt = 1'b0;
    flush_nxt = 1'b0;
    allow_nxt = 1'b0;
    ext_seen_nxt = ext_seen_r;
    take = 1'b0;
    take_kind = EXC_NONE;
    if (reset_req) begin
      take_kind = EXC_RESET;
    end else if (mcheck_req) begin
      take_kind = EXC_MCHECK;
    end else if (state_r != ST_HANDLER && cmp_valid_i && cmp_fault_i && !older_pending_i) begin
      // Only the oldest instruction may fault; imprecise FP modes still land here.
      take_kind = EXC_SYNC;
    end else if (state_r != ST_HANDLER && async_req && store_q_empty_i &&
                 (pipe_empty_i || (ext_seen_r && cmp_valid_i && !older_pending_i))) begin
      take_kind = async_kind;
    end
    take = (take_kind != EXC_NONE);
    if (take) begin
      // Save first, then change the live state.
      sstat_nxt = mstate_r;
      sstat_nxt[MSTATE_RECOV_BIT] = mstate_r[MSTATE_RECOV_BIT] &&
                             take_kind != EXC_RESET && take_kind != EXC_MCHECK;
      if (take_kind == EXC_SYNC) begin
        // Trap and syscall give the next address; faults give their own.
        spc_nxt = cmp_fault_next_i ? cmp_pc_i + ADDR_STEP : cmp_pc_i;
        fetch_nxt = VEC_BASE | cmp_fault_off_i;
        cause_nxt = cmp_cause_i;
      end else begin
        // With the pipe empty the last fetch target is the only restart point known.
        spc_nxt = (cmp_valid_i && !pipe_empty_i) ? cmp_pc_i + ADDR_STEP : fetch_r;
        fetch_nxt = VEC_BASE | kind_off(take_kind);
      end
      // Supervisor mode, translation and EE off until the handler saves; CE is cleared only for critical, reset and check entry.
      mstate_nxt[MSTATE_PR_BIT] = 1'b0;
      mstate_nxt[MSTATE_EE_BIT] = 1'b0;
      mstate_nxt[MSTATE_IR_BIT] = 1'b0;
      mstate_nxt[MSTATE_DR_BIT] = 1'b0;
      mstate_nxt[MSTATE_RECOV_BIT] = 1'b0;
      if (take_kind == EXC_CRIT || take_kind == EXC_RESET || take_kind == EXC_MCHECK) begin
        mstate_nxt[MSTATE_CE_BIT] = 1'b0;
      end
      redir_nxt = 1'b1;
      flush_nxt = 1'b1;
      ext_seen_nxt = 1'b0;
      state_nxt = ST_HANDLER;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          allow_nxt = cmp_valid_i && !cmp_fault_i;
          if (async_req) begin
            // Wait for the next instruction to reach completion and take it there; that instruction gets no cmp_allow_o.
            ext_seen_nxt = 1'b1;
            state_nxt = ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          allow_nxt = cmp_valid_i && !cmp_fault_i;
          if (!async_req) begin
            ext_seen_nxt = 1'b0;
            state_nxt = ST_RUN;
          end
        end
        ST_HANDLER: begin
          allow_nxt = cmp_valid_i && !cmp_fault_i;
          if (handler_return_i) begin
            // Resume after the handler; the next condition is then met anew.
            mstate_nxt = sstat_r;
            fetch_nxt = return_pc_i;
            redir_nxt = 1'b1;
            state_nxt = ST_RUN;
          end
        end
      endcase
    end
    busy_nxt = (state_nxt == ST_HANDLER);
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_RUN;
      spc_r <= PC_RESET;
      sstat_r <= MSTATE_RESET;
      mstate_r <= MSTATE_RESET;
      busy_r <= 1'b0;
      fetch_r <= PC_RESET;
      cause_r <= '0;
      redir_r <= 1'b0;
      flush_r <= 1'b0;
      allow_r <= 1'b0;
      ext_seen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      spc_r <= spc_nxt;
      sstat_r <= sstat_nxt;
      mstate_r <= mstate_nxt;
      busy_r <= busy_nxt;
      fetch_r <= fetch_nxt;
      cause_r <= cause_nxt;
      redir_r <= redir_nxt;
      flush_r <= flush_nxt;
      allow_r <= allow_nxt;
      ext_seen_r <= ext_seen_nxt;
    end
  end

  assign cmp_allow_o = allow_r;
  assign flush_o = flush_r;
  assign redirect_o = redir_r;
  assign fetch_pc_o = fetch_r;
  assign save_restore_pc_o = spc_r;
  assign save_restore_status_o = sstat_r;
  assign machine_state_reg_o = mstate_r;
  assign data_fault_cause_reg_o = cause_r;
  assign busy_o = busy_r;

  // The |=> checks below watch the registered outputs one cycle after each decision; the |-> ones check the decision itself.
  // They are written against the rules, so a wrong priority or save shows up here.

  chk_reset_vector: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    reset_req |=> redirect_o && fetch_pc_o == (VEC_BASE | OFF_RESET))
    else $error("reset did not vector to reset offset");
  chk_mcheck_vector: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!reset_req && mcheck_req) |=> redirect_o && fetch_pc_o == (VEC_BASE | OFF_MCHECK))
    else $error("machine check did not vector to its offset");
  chk_entry_saves: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    take |=> save_restore_status_o[MSTATE_EE_BIT] == $past(mstate_r[MSTATE_EE_BIT]) &&
             !machine_state_reg_o[MSTATE_PR_BIT] && flush_o)
    else $error("entry did not save state and enter supervisor");
  chk_fault_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take_kind == EXC_SYNC && !cmp_fault_next_i) |=> save_restore_pc_o == $past(cmp_pc_i))
    else $error("fault address not saved");
  chk_trap_next: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take_kind == EXC_SYNC && cmp_fault_next_i) |=>
      save_restore_pc_o == $past(cmp_pc_i) + ADDR_STEP)
    else $error("trap restart point wrong");
  chk_one_at_time: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (busy_o && !reset_req && !mcheck_req) |-> !take)
    else $error("second exception taken inside handler");
  chk_store_drain: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take && take_kind >= EXC_CRIT) |-> store_q_empty_i)
    else $error("async exception taken with stores queued");
  chk_program_order: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take && !reset_req && !mcheck_req) |-> !older_pending_i || pipe_empty_i)
    else $error("exception taken before older instructions");
  chk_mask_ee: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take && (take_kind == EXC_EXT || take_kind == EXC_DEC)) |-> mstate_r[MSTATE_EE_BIT])
    else $error("masked interrupt taken");
  chk_ri_cleared: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take && (reset_req || mcheck_req)) |=> !save_restore_status_o[MSTATE_RECOV_BIT])
    else $error("nonmaskable entry reported recoverable");
  chk_ri_live: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    take |=> !machine_state_reg_o[MSTATE_RECOV_BIT])
    else $error("live state still recoverable inside handler");
  chk_return_restore: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (busy_o && handler_return_i && !reset_req && !mcheck_req) |=>
      redirect_o && fetch_pc_o == $past(return_pc_i) && !busy_o)
    else $error("handler return did not resume");
  chk_cause_latch: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take_kind == EXC_SYNC) |=> data_fault_cause_reg_o == $past(cmp_cause_i))
    else $error("fault cause not latched");
  chk_sync_vector: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take_kind == EXC_SYNC) |=> fetch_pc_o == (VEC_BASE | $past(cmp_fault_off_i)))
    else $error("fault did not vector to its offset");
  chk_async_vector: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take && take_kind >= EXC_CRIT) |=> fetch_pc_o == (VEC_BASE | kind_off($past(take_kind))))
    else $error("interrupt did not vector to its offset");
  // A fault in an imprecise floating-point mode must still be taken at once.
  chk_fp_precise: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (fp_imprecise_mode_i && cmp_valid_i && cmp_fault_i && !older_pending_i && !busy_o) |-> take)
    else $error("imprecise mode fault not taken precisely");
  chk_mask_mgmt: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take && take_kind == EXC_MGMT) |-> mstate_r[MSTATE_EE_BIT])
    else $error("masked management interrupt taken");
  chk_mask_crit: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take && take_kind == EXC_CRIT) |-> mstate_r[MSTATE_CE_BIT])
    else $error("masked critical interrupt taken");
  chk_no_complete: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (cmp_valid_i && cmp_fault_i) |=> !cmp_allow_o)
    else $error("faulting instruction allowed to complete");
  chk_allow_clean: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (cmp_valid_i && !cmp_fault_i && !take) |=> cmp_allow_o)
    else $error("clean instruction held back");
  chk_save_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !take |=> $stable(save_restore_pc_o))
    else $error("restart address changed without entry");
  chk_busy_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    take |=> busy_o)
    else $error("entry did not mark the handler busy");
  chk_idle_restart: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take && take_kind >= EXC_CRIT && pipe_empty_i) |=>
      save_restore_pc_o == $past(fetch_pc_o))
    else $error("idle interrupt restart address wrong");
  chk_reset_ce: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (take && reset_req) |=> !machine_state_reg_o[MSTATE_CE_BIT])
    else $error("reset entry left critical interrupts enabled");

  // Main scenarios that the bench should reach.
  cov_reset: cover property (@(posedge clk_sys_i) take_kind == EXC_RESET);
  cov_sync: cover property (@(posedge clk_sys_i) take_kind == EXC_SYNC);
  cov_ext: cover property (@(posedge clk_sys_i) take_kind == EXC_EXT);
  cov_preempt: cover property (@(posedge clk_sys_i) busy_o && take_kind == EXC_MCHECK);
  cov_return: cover property (@(posedge clk_sys_i) busy_o && handler_return_i);
endmodule

//--- sim/completion_model.sv
// Completion-stage model: presents one oldest instruction with a fault.
// Assumes the sequencer answers a taken fault with a one-cycle flush pulse.
module completion_model (
  input wire logic clk_sys_i,
  input wire logic flush_i,
  output logic valid_o,
  output logic [31:0] pc_o,
  output logic fault_o,
  output logic [31:0] off_o,
  output logic next_o,
  output logic [7:0] cause_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {valid_o, fault_o, next_o, pc_o, off_o, cause_o} = '0;
  task automatic issue(input logic [31:0] pc, input logic [31:0] off, input logic nxt,
                       input logic [7:0] cause);
    {pc_o, off_o, next_o, cause_o} = {pc, off, nxt, cause};
    valid_o = 1'b1;
    fault_o = 1'b1;
  endtask
  // A released bus shows the inverse pc and offset, so a stale address can never pass for a match.
  always @(posedge clk_sys_i) begin
    if (flush_i === 1'b1 && fault_o) begin
      #1;
      {valid_o, fault_o} = 2'b00;
      pc_o = ~pc_o;
      off_o = ~off_o;
    end
  end
endmodule

//--- sim/core_exception_sequencer_test.sv
// Self-checking bench for the exception sequencer; a queue holds expected fetch targets.
// Assumes interrupt enables stay clear, since the machine state resets to zero.
module core_exception_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import exc_seq_pkg::*;
  logic clk_sys_i = 0, rst_b_i = 0, older = 0, fpm = 0, ret = 0;
  logic valid, fault, nxt, flush_o, redirect_o, busy_o;
  logic [31:0] pc, off, rpc = 0, fetch_pc_o, srr_pc, srr_st, mstate;
  logic [7:0] cause, dfc;
  logic [8:0] src = 0;
  int mismatches = 0, n_tests = 0, seed = 83;
  logic [31:0] exp_q[$];
  completion_model pm_u (.clk_sys_i(clk_sys_i), .flush_i(flush_o), .valid_o(valid),
    .pc_o(pc), .fault_o(fault), .off_o(off), .next_o(nxt), .cause_o(cause));
  core_exception_sequencer dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .cmp_valid_i(valid), .cmp_pc_i(pc), .cmp_fault_i(fault), .cmp_fault_off_i(off),
    .cmp_fault_next_i(nxt), .cmp_cause_i(cause), .older_pending_i(older),
    .pipe_empty_i(1'b1), .store_q_empty_i(1'b1), .fp_imprecise_mode_i(fpm),
    .soft_reset_i(src[0]), .hard_reset_i(src[1]), .bus_tea_i(src[2]), .mcheck_i(src[3]),
    .parity_err_i(src[4]), .ext_int_i(src[5]), .system_mgmt_interrupt_i(src[6]),
    .dec_int_i(src[7]), .crit_int_i(src[8]), .handler_return_i(ret), .return_pc_i(rpc),
    .cmp_allow_o(), .flush_o(flush_o), .redirect_o(redirect_o), .fetch_pc_o(fetch_pc_o),
    .save_restore_pc_o(srr_pc), .save_restore_status_o(srr_st),
    .machine_state_reg_o(mstate), .data_fault_cause_reg_o(dfc), .busy_o(busy_o));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Any redirect with nothing expected is an exception taken when it must not be.
  always @(posedge clk_sys_i) begin
    if (rst_b_i && redirect_o === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected redirect", 32'h0, fetch_pc_o);
      else chk("fetch_pc_o", exp_q.pop_front(), fetch_pc_o);
    end
  end
  task automatic pulse(input int k, input logic [31:0] vec);
    if (vec != 0) exp_q.push_back(vec);
    src[k] = 1'b1;
    @(posedge clk_sys_i) #1 src[k] = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic do_return();
    rpc = $random(seed) & 32'hffff_fffc;
    exp_q.push_back(rpc);
    ret = 1'b1;
    @(posedge clk_sys_i) #1 ret = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("busy_o", 32'h0, {31'h0, busy_o});
  endtask
  task automatic sync_fault(input logic n, input int hold);
    logic [31:0] a, o;
    logic [7:0] c;
    a = $random(seed) & 32'hffff_fffc;
    o = {20'h0, 4'($random(seed)), 8'h00};
    c = 8'($random(seed));
    fpm = 1'($random(seed));
    older = (hold != 0);
    pm_u.issue(a, o, n, c);
    repeat (hold) @(posedge clk_sys_i);
    #1 older = 1'b0;
    exp_q.push_back(VEC_BASE | o);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("save_restore_pc_o", n ? a + ADDR_STEP : a, srr_pc);
    chk("data_fault_cause_reg_o", {24'h0, c}, {24'h0, dfc});
    chk("busy_o", 32'h1, {31'h0, busy_o});
  endtask
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1 rst_b_i = 1'b1;
    @(posedge clk_sys_i) #1;
    for (int k = 5; k < 9; k++) pulse(k, 32'h0);
    sync_fault(1'b0, 0);
    do_return();
    sync_fault(1'b1, 3);
    pulse(5, 32'h0);
    pulse(4, VEC_BASE | OFF_MCHECK);
    do_return();
    for (int k = 0; k < 5; k++) begin
      pulse(k, VEC_BASE | (k < 2 ? OFF_RESET : OFF_MCHECK));
      chk("recoverable_flag", 32'h0, {31'h0, srr_st[MSTATE_RECOV_BIT]});
      if (busy_o === 1'b1) do_return();
    end
    exp_q.push_back(VEC_BASE | OFF_RESET);
    pm_u.issue(32'h0000_1000, 32'h0000_0700, 1'b0, 8'h01);
    src = 9'h009;
    @(posedge clk_sys_i) #1 src = 9'h000;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("queued expectations", 32'h0, exp_q.size());
    if (busy_o === 1'b1) do_return();
    end_of_test();
  end
endmodule
